// ---- hdl/internal_bus_pkg.sv ----
package internal_bus_pkg;
	localparam int ADDR_WIDTH = 6;
	localparam int DATA_WIDTH = 32;
	localparam int REG_COUNT = 64;
	localparam int MEM_CMD_WIDTH = 4;
	localparam int CTRL_WIDTH = 3;
	localparam int DEST_CLOCK_WIDTH = 2;

	// register map
	localparam logic [5:0] ADDR_PREFETCH = 6'h00;
	localparam logic [5:0] ADDR_UNUSED_02 = 6'h02;
	localparam logic [5:0] ADDR_SYSTEM_IDENTIFICATION = 6'h03;
	localparam logic [5:0] ADDR_RX_STATUS = 6'h04;
	localparam logic [5:0] ADDR_TX_STATUS = 6'h06;
	localparam logic [5:0] ADDR_DATAPATH_DQ = 6'h08;
	localparam logic [5:0] ADDR_CLOCK_STATUS = 6'h0A;
	localparam logic [5:0] ADDR_RSVD_11 = 6'h11;
	localparam logic [5:0] ADDR_RSVD_1F = 6'h1F;
	localparam logic [5:0] ADDR_MICRO_STACK = 6'h20;
	localparam logic [5:0] ADDR_RSVD_27 = 6'h27;
	localparam logic [5:0] ADDR_RSVD_3F = 6'h3F;

	// bus and console control codes
	localparam logic [2:0] CTL_NOP = 3'h0;
	localparam logic [2:0] CTL_UNUSED = 3'h1;
	localparam logic [2:0] CTL_ACK = 3'h2;
	localparam logic [2:0] CTL_CONT = 3'h3;
	localparam logic [2:0] CTL_READ_STEP = 3'h4;
	localparam logic [2:0] CTL_READ_CONST = 3'h5;
	localparam logic [2:0] CTL_WRITE_STEP = 3'h6;
	localparam logic [2:0] CTL_WRITE_CONST = 3'h7;

	// field positions of the status registers
	localparam int RX_DONE_BIT = 7;
	localparam int RX_IE_BIT = 6;
	localparam int TX_READY_BIT = 7;
	localparam int TX_IE_BIT = 6;
	localparam int CLK_INTR_REQ_BIT = 7;
	localparam int CLK_IE_BIT = 6;
	localparam int CLK_SINGLE_BIT = 5;
	localparam int CLK_XFER_BIT = 4;

	localparam logic RX_IE_RESET = 1'b0;
	localparam logic TX_IE_RESET = 1'b0;
	localparam logic CLK_IE_RESET = 1'b0;
	localparam logic CLK_SINGLE_RESET = 1'b0;
	localparam logic CLK_XFER_RESET = 1'b0;
	localparam logic [31:0] BUS_RESET = 32'h0000_0000;

	// arbitrary neutral value
	localparam logic [31:0] SYSTEM_IDENTIFICATION_DEFAULT = 32'h0000_5A5A;

	typedef enum {SRC_PREFETCH, SRC_DATAPATH, SRC_REGISTER, SRC_CONSOLE,
		SRC_NONE} bus_source_type;
endpackage

// ---- hdl/reg_address_decoder.sv ----
`timescale 1ns/1ps
module reg_address_decoder
	import internal_bus_pkg::*;
(
	input wire logic [ADDR_WIDTH-1:0] address,
	input wire logic enable,
	input wire logic maintenance,
	output logic [REG_COUNT-1:0] select,
	output logic hit
);
	logic reserved;

	// unused and reserved slots select nothing
	assign reserved = (address == ADDR_UNUSED_02) ||
		(address == ADDR_RSVD_11) || (address == ADDR_RSVD_1F) ||
		(address == ADDR_RSVD_27) || (address == ADDR_RSVD_3F);

	// the datapath slot answers only under console control
	assign hit = enable && !reserved &&
		((address != ADDR_DATAPATH_DQ) || maintenance);

	always_comb
	begin
		select = '0;
		if (hit)
		begin
			select[address] = 1'b1;
		end
	end
endmodule

// ---- hdl/internal_register_bus_control.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// - transfers take data from the source register, deliver into destination
// - accelerator snapshots prefetch data moving to the destination register
// - six-bit address picks the one register used by this transfer
// - 64-slot map; unused and reserved slots select nothing
// - direction high: register drives bus; low: register loads bus
// - 32 data lines, six address lines and one direction line
// - left and right copies of address and direction, equal
// - function-select bit picks memory or internal-bus control
// - function-select low forces address and direction zero, prefetch on bus
// - function-select low: field is a memory command, no register access
// - destination clock field picks when destination loads, except on writes and in maintenance
// - codes 4,5 read and 6,7 write by step counter or constant
// - address comes from step counter or microword constant
// - code 0 no-op, 1 unused, 2 acknowledge, 3 continue
// - maintenance select hands address, direction, data to console
// - console reaches control store, stack and registers without microcode
// - datapath slot 08 answers only in maintenance
module internal_register_bus_control
	import internal_bus_pkg::*;
#(
	parameter logic [31:0] SYSTEM_IDENTIFICATION = SYSTEM_IDENTIFICATION_DEFAULT
)
(
	input wire logic mclk,
	input wire logic resetn,
	input wire logic clockEnable,
	input wire logic functionSelectBit,
	input wire logic [MEM_CMD_WIDTH-1:0] memoryControlField,
	input wire logic [DEST_CLOCK_WIDTH-1:0] destinationClockField,
	input wire logic [ADDR_WIDTH-1:0] microwordConstantField,
	input wire logic [ADDR_WIDTH-1:0] stepCounterRegister,
	input wire logic [DATA_WIDTH-1:0] sourceRegisterData,
	input wire logic [DATA_WIDTH-1:0] prefetchBufferData,
	input wire logic consoleMaintenanceSelect,
	input wire logic [ADDR_WIDTH-1:0] consoleAddress,
	input wire logic consoleDirection,
	input wire logic consoleDataDrive,
	input wire logic [DATA_WIDTH-1:0] consoleData,
	input wire logic [DATA_WIDTH-1:0] externalReadData,
	input wire logic receiveDone,
	input wire logic transmitReady,
	input wire logic clockInterruptRequest,
	output logic [ADDR_WIDTH-1:0] leftRegisterAddress,
	output logic [ADDR_WIDTH-1:0] rightRegisterAddress,
	output logic leftDirectionLine,
	output logic rightDirectionLine,
	output logic [DATA_WIDTH-1:0] internalRegisterBus,
	output logic [REG_COUNT-1:0] registerReadSelect,
	output logic [REG_COUNT-1:0] registerLoadSelect,
	output logic registerLoad,
	output logic destinationLoad,
	output logic acceleratorSnapshot,
	output logic consoleAcknowledge,
	output logic consoleContinue,
	output logic memoryCommandValid,
	output logic [MEM_CMD_WIDTH-1:0] memoryCommand,
	output logic receiveInterruptEnable,
	output logic transmitInterruptEnable,
	output logic clockInterruptEnable,
	output logic clockSingleStep,
	output logic clockTransfer
);
	typedef struct packed {
		logic [ADDR_WIDTH-1:0] address;
		logic direction;
		logic [DATA_WIDTH-1:0] busData;
		logic [REG_COUNT-1:0] loadSelect;
		logic registerLoad;
		logic destinationLoad;
		logic snapshot;
		logic ack;
		logic cont;
		logic memValid;
		logic [MEM_CMD_WIDTH-1:0] memCmd;
		logic rxIe;
		logic txIe;
		logic clkIe;
		logic clkSingle;
		logic clkXfer;
	} state_type;

	localparam state_type STATE_RESET = '{
		address: ADDR_PREFETCH,
		direction: 1'b0,
		busData: BUS_RESET,
		loadSelect: '0,
		registerLoad: 1'b0,
		destinationLoad: 1'b0,
		snapshot: 1'b0,
		ack: 1'b0,
		cont: 1'b0,
		memValid: 1'b0,
		memCmd: '0,
		rxIe: RX_IE_RESET,
		txIe: TX_IE_RESET,
		clkIe: CLK_IE_RESET,
		clkSingle: CLK_SINGLE_RESET,
		clkXfer: CLK_XFER_RESET
	};

	state_type state;
	state_type next_state;

	logic [ADDR_WIDTH-1:0] workAddress;
	logic workDirection;
	logic access;
	logic readHit;
	logic writeHit;
	logic [REG_COUNT-1:0] writeSelect;
	logic [DATA_WIDTH-1:0] readValue;
	logic [DATA_WIDTH-1:0] writeValue;
	logic destClockActive;
	bus_source_type busSource;

	assign destClockActive = (destinationClockField != '0);

	// choose who controls the bus this cycle; console wins
	always_comb
	begin
		workAddress = ADDR_PREFETCH;
		workDirection = 1'b0;
		access = 1'b0;
		if (consoleMaintenanceSelect)
		begin
			workAddress = consoleAddress;
			workDirection = consoleDirection;
			access = 1'b1;
		end
		else if (functionSelectBit)
		begin
			case (memoryControlField[CTRL_WIDTH-1:0])
				CTL_READ_STEP, CTL_READ_CONST, CTL_WRITE_STEP,
				CTL_WRITE_CONST:
				begin
					// low code bit picks the constant, middle bit a write
					workAddress = memoryControlField[0] ?
						microwordConstantField : stepCounterRegister;
					workDirection = !memoryControlField[1];
					access = 1'b1;
				end
				// codes 0-3: no register access, prefetch data holds the bus
				default: access = 1'b0;
			endcase
		end
	end

	// read decoder faces the addressed registers this cycle
	reg_address_decoder readDecoder (
		.address(workAddress),
		.enable(access && workDirection),
		.maintenance(consoleMaintenanceSelect),
		.select(registerReadSelect),
		.hit(readHit)
	);

	reg_address_decoder writeDecoder (
		.address(workAddress),
		.enable(access && !workDirection),
		.maintenance(consoleMaintenanceSelect),
		.select(writeSelect),
		.hit(writeHit)
	);

	// value driven by the addressed register; empty slots read zero
	always_comb
	begin
		readValue = '0;
		if (readHit)
		begin
			case (workAddress)
				ADDR_PREFETCH: readValue = prefetchBufferData;
				ADDR_SYSTEM_IDENTIFICATION: readValue = SYSTEM_IDENTIFICATION;
				ADDR_DATAPATH_DQ: readValue = sourceRegisterData;
				ADDR_RX_STATUS:
					readValue[RX_DONE_BIT:RX_IE_BIT] =
						{receiveDone, state.rxIe};
				ADDR_TX_STATUS:
					readValue[TX_READY_BIT:TX_IE_BIT] =
						{transmitReady, state.txIe};
				ADDR_CLOCK_STATUS:
					readValue[CLK_INTR_REQ_BIT:CLK_XFER_BIT] =
						{clockInterruptRequest, state.clkIe,
						state.clkSingle, state.clkXfer};
				default: readValue = externalReadData;
			endcase
		end
	end

	// writes come from the source register unless the console drives
	assign writeValue = (consoleMaintenanceSelect && consoleDataDrive) ?
		consoleData : sourceRegisterData;

	always_comb
	begin
		busSource = SRC_PREFETCH;
		if (access && workDirection)
		begin
			busSource = readHit ? SRC_REGISTER : SRC_NONE;
		end
		else if (access)
		begin
			busSource = (consoleMaintenanceSelect && consoleDataDrive) ?
				SRC_CONSOLE : SRC_DATAPATH;
		end
	end

	always_comb
	begin
		next_state = state;
		next_state.registerLoad = 1'b0;
		next_state.loadSelect = '0;
		next_state.destinationLoad = 1'b0;
		next_state.snapshot = 1'b0;
		next_state.ack = 1'b0;
		next_state.cont = 1'b0;
		next_state.memValid = 1'b0;
		next_state.address = workAddress;
		next_state.direction = workDirection;
		case (busSource)
			SRC_PREFETCH: next_state.busData = prefetchBufferData;
			SRC_REGISTER: next_state.busData = readValue;
			SRC_DATAPATH: next_state.busData = sourceRegisterData;
			SRC_CONSOLE: next_state.busData = consoleData;
			default: next_state.busData = '0;
		endcase
		if (!consoleMaintenanceSelect && !functionSelectBit)
		begin
			next_state.memValid = 1'b1;
			next_state.memCmd = memoryControlField;
		end
		if (!consoleMaintenanceSelect && functionSelectBit)
		begin
			next_state.ack = (memoryControlField[2:0] == CTL_ACK);
			next_state.cont = (memoryControlField[2:0] == CTL_CONT);
		end
		// the destination register loads at its own clock field unless a write runs; in maintenance only on a write to slot 08
		next_state.destinationLoad = consoleMaintenanceSelect ?
			(writeHit && workAddress == ADDR_DATAPATH_DQ) :
			(destClockActive && !(access && !workDirection));
		next_state.snapshot = next_state.destinationLoad &&
			(busSource == SRC_PREFETCH ||
			(busSource == SRC_REGISTER &&
			workAddress == ADDR_PREFETCH));
		if (writeHit)
		begin
			next_state.registerLoad = 1'b1;
			next_state.loadSelect = writeSelect;
			case (workAddress)
				ADDR_RX_STATUS: next_state.rxIe = writeValue[RX_IE_BIT];
				ADDR_TX_STATUS: next_state.txIe = writeValue[TX_IE_BIT];
				ADDR_CLOCK_STATUS: {next_state.clkIe, next_state.clkSingle,
					next_state.clkXfer} = writeValue[CLK_IE_BIT:CLK_XFER_BIT];
				default: next_state.rxIe = state.rxIe;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			state <= STATE_RESET;
		end
		else if (clockEnable)
		begin
			state <= next_state;
		end
	end

	// both copies carry the same address and direction
	assign leftRegisterAddress = state.address;
	assign rightRegisterAddress = state.address;
	assign leftDirectionLine = state.direction;
	assign rightDirectionLine = state.direction;
	assign internalRegisterBus = state.busData;
	assign registerLoadSelect = state.loadSelect;
	assign registerLoad = state.registerLoad;
	assign destinationLoad = state.destinationLoad;
	assign acceleratorSnapshot = state.snapshot;
	assign consoleAcknowledge = state.ack;
	assign consoleContinue = state.cont;
	assign memoryCommandValid = state.memValid;
	assign memoryCommand = state.memCmd;
	assign receiveInterruptEnable = state.rxIe;
	assign transmitInterruptEnable = state.txIe;
	assign clockInterruptEnable = state.clkIe;
	assign clockSingleStep = state.clkSingle;
	assign clockTransfer = state.clkXfer;

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!resetn);

	sequence seqNormalMicro;
		clockEnable && !consoleMaintenanceSelect && functionSelectBit;
	endsequence

	sequence seqConsoleRxWrite;
		clockEnable && consoleMaintenanceSelect && !consoleDirection &&
			consoleDataDrive && consoleAddress == ADDR_RX_STATUS;
	endsequence

	chk_prefetch_default: assert property (
		clockEnable && !consoleMaintenanceSelect && !functionSelectBit |=>
		leftRegisterAddress == 6'h00 && !leftDirectionLine &&
		internalRegisterBus == $past(prefetchBufferData))
		else $error("prefetch data not defaulted onto bus");

	chk_memory_command: assert property (
		clockEnable && !consoleMaintenanceSelect && !functionSelectBit |=>
		memoryCommandValid && memoryCommand == $past(memoryControlField) &&
		!registerLoad)
		else $error("memory command misrouted");

	chk_snapshot_prefetch: assert property (
		clockEnable && !consoleMaintenanceSelect && !functionSelectBit &&
		destinationClockField != 2'h0 |=>
		acceleratorSnapshot && destinationLoad)
		else $error("accelerator missed prefetch transfer");

	chk_step_read: assert property (
		seqNormalMicro ##0 memoryControlField[2:0] == 3'h4 |=>
		leftRegisterAddress == $past(stepCounterRegister) &&
		leftDirectionLine)
		else $error("step counter read wrong");

	chk_const_write: assert property (
		seqNormalMicro ##0 memoryControlField[2:0] == 3'h7 |=>
		leftRegisterAddress == $past(microwordConstantField) &&
		!leftDirectionLine &&
		internalRegisterBus == $past(sourceRegisterData))
		else $error("constant write wrong");

	chk_dq_normal: assert property (
		seqNormalMicro ##0 memoryControlField[2:1] == 2'h3 &&
		workAddress == 6'h08 |=> !registerLoad && !destinationLoad)
		else $error("datapath slot answered outside maintenance");

	chk_console_ack: assert property (
		seqNormalMicro ##0 memoryControlField[2:0] == 3'h2 |=>
		consoleAcknowledge && !consoleContinue && !registerLoad)
		else $error("console acknowledge not issued");

	chk_maint_override: assert property (
		clockEnable && consoleMaintenanceSelect |=>
		leftRegisterAddress == $past(consoleAddress) &&
		leftDirectionLine == $past(consoleDirection) && !memoryCommandValid)
		else $error("console did not take the bus");

	chk_copies_equal: assert property (
		leftRegisterAddress == rightRegisterAddress &&
		leftDirectionLine == rightDirectionLine)
		else $error("address copies disagree");

	chk_reserved_quiet: assert property (
		registerLoad |-> $onehot(registerLoadSelect) &&
		!registerLoadSelect[6'h02] && !registerLoadSelect[6'h3F])
		else $error("load reached an empty slot");

	chk_console_store: assert property (
		seqConsoleRxWrite |=> registerLoad &&
		receiveInterruptEnable == $past(consoleData[6]) &&
		registerLoadSelect[6'h04])
		else $error("console write not stored");
endmodule

// ---- sim/register_partner.sv ----
`timescale 1ns/1ps
module register_partner
	import internal_bus_pkg::*;
(
	input wire logic mclk,
	input wire logic [REG_COUNT-1:0] readSelect,
	input wire logic [REG_COUNT-1:0] loadSelect,
	input wire logic load,
	input wire logic destLoad,
	input wire logic snapshot,
	input wire logic [DATA_WIDTH-1:0] bus,
	output logic [DATA_WIDTH-1:0] readData
);
	logic [DATA_WIDTH-1:0] regs [REG_COUNT];
	logic [DATA_WIDTH-1:0] destReg = 32'h0000_0000;
	logic [DATA_WIDTH-1:0] accCopy = 32'h0000_0000;
	// unselected lines wander so a stale value never passes for a read
	logic [DATA_WIDTH-1:0] noise = 32'h5A3C_0F96;
	initial
	begin
		for (int i = 0; i < REG_COUNT; i++)
			regs[i] = 32'h1357_0000 + 32'(i) * 32'h0000_0301;
	end
	always_comb
	begin
		readData = noise;
		for (int i = 0; i < REG_COUNT; i++)
			if (readSelect[i])
				readData = regs[i];
	end
	always @(posedge mclk)
	begin
		noise <= {noise[30:0], noise[31] ^ noise[21]};
		for (int i = 0; i < REG_COUNT; i++)
			if (load && loadSelect[i])
				regs[i] <= bus;
		if (destLoad)
			destReg <= bus;
		if (snapshot)
			accCopy <= bus;
	end
endmodule

// ---- sim/test_internal_register_bus_control.sv ----
`timescale 1ns/1ps
module test_internal_register_bus_control
	import internal_bus_pkg::*;
();
	logic mclk, resetn, ce, fs, mt, cd, cdd, rxd, txr, cir, t, e, f;
	logic [3:0] mcf, mCmd, eMc, m;
	logic [1:0] dcf;
	logic [5:0] kc, sc, ca, lAddr, rAddr, eA;
	logic [31:0] src, pre, cdat, xrd, bus, eB, eAcc, eDst;
	logic [63:0] rSel, lSel, eLs;
	logic lDir, rDir, rLoad, dLoad, snap, ack, cont, mValid;
	logic eD, eL, eDl, eSn, eAck, eCont, eMv;
	logic [4:0] sh, oBits;
	logic [5:0] odd [8] = '{6'h02, 6'h11, 6'h1F, 6'h27, 6'h3F, 6'h08,
		6'h00, 6'h03};
	int err_total = 0;
	int checks = 0;

	internal_register_bus_control dut (
		.mclk(mclk), .resetn(resetn), .clockEnable(ce),
		.functionSelectBit(fs),
		.memoryControlField(mcf), .destinationClockField(dcf),
		.microwordConstantField(kc), .stepCounterRegister(sc),
		.sourceRegisterData(src), .prefetchBufferData(pre),
		.consoleMaintenanceSelect(mt), .consoleAddress(ca),
		.consoleDirection(cd), .consoleDataDrive(cdd), .consoleData(cdat),
		.externalReadData(xrd), .receiveDone(rxd), .transmitReady(txr),
		.clockInterruptRequest(cir), .leftRegisterAddress(lAddr),
		.rightRegisterAddress(rAddr), .leftDirectionLine(lDir),
		.rightDirectionLine(rDir), .internalRegisterBus(bus),
		.registerReadSelect(rSel), .registerLoadSelect(lSel),
		.registerLoad(rLoad), .destinationLoad(dLoad),
		.acceleratorSnapshot(snap), .consoleAcknowledge(ack),
		.consoleContinue(cont), .memoryCommandValid(mValid),
		.memoryCommand(mCmd), .receiveInterruptEnable(oBits[4]),
		.transmitInterruptEnable(oBits[3]), .clockInterruptEnable(oBits[2]),
		.clockSingleStep(oBits[1]), .clockTransfer(oBits[0])
	);
	register_partner mdl (
		.mclk(mclk), .readSelect(rSel), .loadSelect(lSel), .load(rLoad),
		.destLoad(dLoad), .snapshot(snap), .bus(bus), .readData(xrd)
	);

	task automatic chk(input string n, input logic [63:0] x, g);
		checks++;
		if (x !== g)
		begin
			err_total++;
			$display("wrong value %s expected %h seen %h", n, x, g);
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// writes to read-only slots are steered elsewhere, their effect is open
	function automatic logic [5:0] fx(input logic [5:0] x);
		return (x == 6'h00 || x == 6'h03) ? x | 6'h10 : x;
	endfunction

	task automatic calc();
		logic [5:0] a;
		logic r, w, ok;
		logic [31:0] v;
		r = mt ? cd : fs && mcf[2:1] == 2'h2;
		w = mt ? !cd : fs && mcf[2:1] == 2'h3;
		a = mt ? ca : mcf[0] ? kc : sc;
		if (!r && !w)
			a = 6'h00;
		ok = !(a inside {6'h02, 6'h11, 6'h1F, 6'h27, 6'h3F});
		ok = ok && (mt || a != 6'h08);
		chk("read select", (r && ok) ? 64'h1 << a : 64'h0, rSel);
		if (!ce)
			return;
		case (a)
			6'h00: v = pre;
			6'h03: v = SYSTEM_IDENTIFICATION_DEFAULT;
			6'h04: v = {24'h0, rxd, sh[4], 6'h0};
			6'h06: v = {24'h0, txr, sh[3], 6'h0};
			6'h08: v = src;
			6'h0A: v = {24'h0, cir, sh[2:0], 4'h0};
			default: v = xrd;
		endcase
		eA = a;
		eD = r;
		eB = r ? (ok ? v : 32'h0) : w ? (mt && cdd ? cdat : src) : pre;
		eL = w && ok;
		eLs = eL ? 64'h1 << a : 64'h0;
		eDl = mt ? eL && a == 6'h08 : dcf != 2'h0 && !w;
		eSn = eDl && !w && (!r || a == 6'h00);
		eAck = !mt && fs && mcf[2:0] == CTL_ACK;
		eCont = !mt && fs && mcf[2:0] == CTL_CONT;
		eMv = !mt && !fs;
		if (eMv)
			eMc = mcf;
		if (eL && a == 6'h04)
			sh[4] = eB[6];
		if (eL && a == 6'h06)
			sh[3] = eB[6];
		if (eL && a == 6'h0A)
			sh[2:0] = eB[6:4];
	endtask

	task automatic cmp();
		// far-side copies lag the pulses by one edge
		chk("accelerator copy", eAcc, mdl.accCopy);
		chk("destination copy", eDst, mdl.destReg);
		chk("address", {eA, eA}, {lAddr, rAddr});
		chk("direction", {eD, eD}, {lDir, rDir});
		chk("bus", eB, bus);
		chk("load select", eLs, lSel);
		chk("pulses", {eL, eDl, eSn}, {rLoad, dLoad, snap});
		chk("console", {eAck, eCont}, {ack, cont});
		chk("memory", {eMv, eMc}, {mValid, mCmd});
		chk("stored bits", sh, oBits);
		if (eSn)
			eAcc = eB;
		if (eDl)
			eDst = eB;
	endtask

	task automatic go(input logic en, fsel, input logic [3:0] mc,
		input logic [5:0] k, s, input logic mn, input logic [5:0] c,
		input logic d);
		logic w;
		w = mn ? !d : fsel && mc[2:1] == 2'h3;
		@(posedge mclk);
		ce <= en;
		fs <= fsel;
		mcf <= mc;
		kc <= w ? fx(k) : k;
		sc <= w ? fx(s) : s;
		ca <= w ? fx(c) : c;
		mt <= mn;
		cd <= d;
		dcf <= 2'($urandom);
		cdd <= 1'($urandom);
		{rxd, txr, cir} <= 3'($urandom);
		src <= $urandom;
		pre <= $urandom;
		cdat <= $urandom;
		#1 cmp();
		#19 calc();
	endtask

	initial
	begin
		mclk = 1'b0;
		forever
			#12.5 mclk = ~mclk;
	end

	initial
	begin
		#100000;
		err_total++;
		print_verdict();
	end

	initial
	begin
		{resetn, fs, mt, cd, cdd, rxd, txr, cir} = 8'h00;
		ce = 1'b1;
		{mcf, dcf, kc, sc, ca} = 24'h00_0000;
		{src, pre, cdat, eAcc, eDst} = 160'h0;
		{sh, eMc} = 9'h000;
		void'($urandom(2));
		repeat (5)
			@(posedge mclk);
		#1 chk("reset", 64'h0, {lAddr, lDir, bus, rLoad, mValid, oBits});
		@(posedge mclk);
		resetn <= 1'b1;
		#20 calc();
		go(1, 0, 4'h9, 6'h00, 6'h00, 0, 6'h00, 0);
		for (int c = 0; c < 16; c++)
			go(1, 1, 4'(c), 6'h0A, 6'h04, 0, 6'h00, 0);
		foreach (odd[i])
			for (int c = 4; c < 8; c++)
				go(1, 1, 4'(c), odd[i], odd[i], 0, 6'h00, 0);
		// upper half writes the receive status from the console
		for (int c = 0; c < 16; c++)
			go(1, 1, 4'(c % 2), 0, 0, 1, c[3] ? 6'h04 : c[1] ? 6'h08 : 6'h20,
				c[2] && !c[3]);
		go(0, 1, 4'h7, 6'h0A, 6'h00, 0, 6'h00, 0);
		for (int n = 0; n < 500; n++)
		begin
			t = $urandom % 6 == 0;
			e = $urandom % 10 != 0;
			f = t | 1'($urandom);
			m = t ? 4'($urandom % 2) : 4'($urandom);
			go(e, f, m, 6'($urandom), 6'($urandom), t, 6'($urandom),
				1'($urandom));
		end
		@(posedge mclk);
		#1 cmp();
		print_verdict();
	end
endmodule
